//--- inc/ptm_pkg.sv
// package for the periodic timer block
package ptm_pkg;

  // register word addresses (one register per word)
  localparam logic [3:0] PTM_ADDR_CTRL0 = 4'h0;
  localparam logic [3:0] PTM_ADDR_CTRL1 = 4'h1;
  localparam logic [3:0] PTM_ADDR_COUNT = 4'h2;
  localparam logic [3:0] PTM_ADDR_CMPA = 4'h3;
  localparam logic [3:0] PTM_ADDR_CMPP = 4'h4;
  localparam logic [3:0] PTM_ADDR_FLAGS = 4'h5;

  // control one fields
  localparam int PTM_C1_MODE_LSB = 6;
  localparam int PTM_C1_PIN_LSB = 4;
  localparam int PTM_C1_LEVEL = 3;
  localparam int PTM_C1_INVERT = 2;
  localparam int PTM_C1_RSVD = 1;
  localparam int PTM_C1_CLRSEL = 0;
  localparam logic [7:0] PTM_C1_RESET = 8'h00;

  // control zero fields
  localparam int PTM_C0_PAUSE = 7;
  localparam int PTM_C0_CLKSEL_LSB = 4;
  localparam int PTM_C0_ON = 3;
  localparam logic [7:0] PTM_C0_RESET = 8'h00;

  // flag bits
  localparam int PTM_FLAG_A = 0;
  localparam int PTM_FLAG_P = 1;

  localparam int PTM_CNT_WIDTH = 10;

  typedef enum logic [1:0] {
    PTM_MODE_COMPARE = 2'b00,
    PTM_MODE_UNDEF = 2'b01,
    PTM_MODE_PWM = 2'b10,
    PTM_MODE_TIMER = 2'b11
  } ptm_mode_t;

  typedef enum logic [1:0] {
    PTM_PIN_P0 = 2'b00,
    PTM_PIN_P1 = 2'b01,
    PTM_PIN_P2 = 2'b10,
    PTM_PIN_P3 = 2'b11
  } ptm_pin_t;
endpackage

//--- design/ptm_tick_gen.sv
// timer clock tick generator with external pin synchroniser
`timescale 1ns/1ps
`default_nettype none
module ptm_tick_gen
  import ptm_pkg::*;
#(
  parameter int DIV_FAST = 4,
  parameter int DIV_MID = 16,
  parameter int DIV_SLOW = 64,
  parameter int DIV_SUB = 256
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // selection
  input wire logic [2:0] clockSelect,
  input wire logic extPin,
  // tick out
  output logic tick
);
  logic [15:0] divCount;
  logic extSync1;
  logic extSync2;
  logic extLast;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      divCount <= 16'h0000;
    end else begin
      divCount <= divCount + 16'h0001;
    end
  end

  // external pin passes two flops before use
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      extSync1 <= 1'b0;
      extSync2 <= 1'b0;
      extLast <= 1'b0;
    end else begin
      extSync1 <= extPin;
      extSync2 <= extSync1;
      extLast <= extSync2;
    end
  end

  function automatic logic divHit(input logic [15:0] cnt, input int div);
    logic [15:0] mask;
    mask = 16'(div - 1);
    divHit = (cnt & mask) == mask;
  endfunction

  always_comb begin
    unique case (clockSelect)
      3'b000: tick = divHit(divCount, DIV_FAST);
      3'b001: tick = 1'b1;
      3'b010: tick = divHit(divCount, DIV_MID);
      3'b011: tick = divHit(divCount, DIV_SLOW);
      3'b100, 3'b101: tick = divHit(divCount, DIV_SUB);
      3'b110: tick = extSync2 & ~extLast;
      3'b111: tick = ~extSync2 & extLast;
    endcase
  end
endmodule
`default_nettype wire

//--- design/ptm_timer.sv
// periodic timer with compare, pwm, single pulse and timer modes
`timescale 1ns/1ps
`default_nettype none
module ptm_timer
  import ptm_pkg::*;
#(
  parameter int CNT_WIDTH = PTM_CNT_WIDTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // pins
  input wire logic timer_clock_pin,
  output logic timer_output_pin,
  output logic timer_output_pin_oe_b
);
  import ptm_pkg::*;

  logic [7:0] timer_control_zero;
  logic [7:0] timer_control_one;
  logic [CNT_WIDTH-1:0] counter;
  logic [CNT_WIDTH-1:0] compare_a_value;
  logic [CNT_WIDTH-1:0] compare_p_value;
  logic compare_a_flag;
  logic compare_p_flag;
  logic pinLevel;
  logic onLast;
  logic tick;
  logic accessDone;
  logic pulseArmed;
  logic extSyncA;
  logic extSyncB;
  logic extPrev;

  ptm_mode_t mode;
  ptm_pin_t pinFunc;
  logic levelSel;
  logic invertSel;
  logic clearSel;
  logic timerOn;
  logic paused;
  logic onRise;
  logic running;
  logic matchA;
  logic matchP;
  logic atMax;
  logic pZero;
  logic aZero;
  logic pulseMode;
  logic clearNow;
  logic raiseA;
  logic raiseP;
  logic pwmActive;
  logic next_pinLevel;
  logic driveOut;
  logic wrCtrl0;
  logic wrFlags;
  logic pulseTrigger;
  logic pulseStop;
  logic matchTick;
  logic [2:0] clkSel;
  logic [31:0] next_readdata;

  assign mode = ptm_mode_t'(timer_control_one[PTM_C1_MODE_LSB +: 2]);
  assign pinFunc = ptm_pin_t'(timer_control_one[PTM_C1_PIN_LSB +: 2]);
  assign levelSel = timer_control_one[PTM_C1_LEVEL];
  assign invertSel = timer_control_one[PTM_C1_INVERT];
  assign clearSel = timer_control_one[PTM_C1_CLRSEL];
  assign timerOn = timer_control_zero[PTM_C0_ON];
  assign paused = timer_control_zero[PTM_C0_PAUSE];
  assign clkSel = timer_control_zero[PTM_C0_CLKSEL_LSB +: 3];
  assign onRise = timerOn & ~onLast;
  assign running = timerOn & ~paused & ~onRise;
  assign pulseMode = (mode == PTM_MODE_PWM) && (pinFunc == PTM_PIN_P3);

  assign atMax = &counter;
  assign pZero = ~|compare_p_value;
  assign aZero = ~|compare_a_value;
  // matches are taken on the tick that reaches the compare value
  assign matchTick = running & tick;
  assign matchA = matchTick & ~aZero & (counter + 1'b1 == compare_a_value);
  assign matchP = matchTick & ~pZero & (counter + 1'b1 == compare_p_value);

  // clear source by mode
  always_comb begin
    clearNow = 1'b0;
    raiseA = 1'b0;
    raiseP = 1'b0;
    unique case (mode)
      PTM_MODE_PWM: begin
        // clear select plays no part here
        clearNow = pulseMode ? 1'b0 : (pZero ? (running & tick & atMax) : matchP);
        raiseA = matchA;
        raiseP = ~pulseMode & matchP;
      end
      PTM_MODE_UNDEF: begin
        clearNow = 1'b0;
      end
      default: begin
        if (clearSel) begin
          clearNow = matchA;
          raiseA = matchA;
        end else begin
          clearNow = pZero ? (running & tick & atMax) : matchP;
          raiseA = matchA;
          raiseP = matchP;
        end
      end
    endcase
  end

  // counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      counter <= '0;
    end else if (onRise) begin
      counter <= '0;
    end else if (running & tick) begin
      if (clearNow) begin
        counter <= '0;
      end else if (!(pulseMode && matchA)) begin
        counter <= counter + 1'b1;
      end
    end
  end

  // timer_on edge detect
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      onLast <= 1'b0;
    end else begin
      onLast <= timerOn;
    end
  end

  // count at or after duty gives inactive part, unless duty is at or above a nonzero period
  always_comb begin
    if (pZero) begin
      pwmActive = counter < compare_a_value;
    end else begin
      pwmActive = (compare_a_value >= compare_p_value) || (counter < compare_a_value);
    end
  end

  // pin level before polarity
  always_comb begin
    next_pinLevel = pinLevel;
    if (onRise) begin
      next_pinLevel = (mode == PTM_MODE_COMPARE) ? levelSel : 1'b0;
    end else begin
      unique case (mode)
        PTM_MODE_COMPARE: begin
          if (raiseA) begin
            unique case (pinFunc)
              PTM_PIN_P0: next_pinLevel = pinLevel;
              PTM_PIN_P1: next_pinLevel = 1'b0;
              PTM_PIN_P2: next_pinLevel = 1'b1;
              PTM_PIN_P3: next_pinLevel = ~pinLevel;
            endcase
          end
        end
        PTM_MODE_PWM: begin
          unique case (pinFunc)
            PTM_PIN_P0: next_pinLevel = 1'b0;
            PTM_PIN_P1: next_pinLevel = 1'b1;
            PTM_PIN_P2: next_pinLevel = timerOn & pwmActive;
            PTM_PIN_P3: next_pinLevel = timerOn & pulseArmed;
          endcase
        end
        default: next_pinLevel = pinLevel;
      endcase
    end
  end

  // pin level is held as active/inactive in pwm, absolute in compare
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinLevel <= 1'b0;
    end else begin
      pinLevel <= next_pinLevel;
    end
  end

  // in pwm the level bit names the active level
  always_comb begin
    unique case (mode)
      PTM_MODE_PWM: driveOut = (next_pinLevel ~^ levelSel) ^ invertSel;
      PTM_MODE_COMPARE: driveOut = next_pinLevel ^ invertSel;
      default: driveOut = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_output_pin <= 1'b0;
    end else begin
      timer_output_pin <= driveOut;
    end
  end

  // pin released where the timer does not own it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_output_pin_oe_b <= 1'b1;
    end else begin
      timer_output_pin_oe_b <= (mode == PTM_MODE_TIMER) || (mode == PTM_MODE_UNDEF);
    end
  end

  // single pulse arm and trigger from the clock pin
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      extSyncA <= 1'b0;
      extSyncB <= 1'b0;
      extPrev <= 1'b0;
    end else begin
      extSyncA <= timer_clock_pin;
      extSyncB <= extSyncA;
      extPrev <= extSyncB;
    end
  end

  // pulse trigger edge follows the clock-select edge choice
  always_comb begin
    unique case (clkSel)
      3'b110: pulseTrigger = pulseMode & ~timerOn & extSyncB & ~extPrev;
      3'b111: pulseTrigger = pulseMode & ~timerOn & ~extSyncB & extPrev;
      default: pulseTrigger = 1'b0;
    endcase
  end
  assign pulseStop = pulseMode & matchA;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pulseArmed <= 1'b0;
    end else if (onRise) begin
      pulseArmed <= 1'b1;
    end else if (pulseStop || !timerOn) begin
      pulseArmed <= 1'b0;
    end
  end

  // timer clock tick source
  ptm_tick_gen u_tick (
    .clk(clk),
    .rst_b(rst_b),
    .clockSelect(clkSel),
    .extPin(timer_clock_pin),
    .tick(tick)
  );

  // bus: one wait cycle per access
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      accessDone <= 1'b0;
    end else begin
      accessDone <= (avs_read | avs_write) & ~accessDone;
    end
  end

  // write strobes qualified by the wait cycle
  assign wrCtrl0 = avs_write & accessDone & avs_byteenable[0] & (avs_address == PTM_ADDR_CTRL0);
  assign wrFlags = avs_write & accessDone & avs_byteenable[0] & (avs_address == PTM_ADDR_FLAGS);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_control_zero <= PTM_C0_RESET;
    end else if (pulseStop) begin
      timer_control_zero[PTM_C0_ON] <= 1'b0;
    end else if (pulseTrigger) begin
      timer_control_zero[PTM_C0_ON] <= 1'b1;
    end else if (wrCtrl0) begin
      timer_control_zero <= {avs_writedata[7:3], 3'b000};
    end
  end

  // control one keeps the reserved bit as written
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_control_one <= PTM_C1_RESET;
    end else if (avs_write & accessDone & avs_byteenable[0] & (avs_address == PTM_ADDR_CTRL1)) begin
      timer_control_one <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      compare_a_value <= '0;
      compare_p_value <= '0;
    end else if (avs_write & accessDone) begin
      unique case (avs_address)
        PTM_ADDR_CMPA: compare_a_value <= CNT_WIDTH'(avs_writedata);
        PTM_ADDR_CMPP: compare_p_value <= CNT_WIDTH'(avs_writedata);
        default: ;
      endcase
    end
  end

  // flags: set wins over a write-one clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      compare_a_flag <= 1'b0;
      compare_p_flag <= 1'b0;
    end else begin
      compare_a_flag <= raiseA | (compare_a_flag & ~(wrFlags & avs_writedata[PTM_FLAG_A]));
      compare_p_flag <= raiseP | (compare_p_flag & ~(wrFlags & avs_writedata[PTM_FLAG_P]));
    end
  end

  always_comb begin
    next_readdata = 32'h00000000;
    unique case (avs_address)
      PTM_ADDR_CTRL0: next_readdata[7:0] = timer_control_zero;
      PTM_ADDR_CTRL1: next_readdata[7:0] = timer_control_one;
      PTM_ADDR_COUNT: next_readdata[CNT_WIDTH-1:0] = counter;
      PTM_ADDR_CMPA: next_readdata[CNT_WIDTH-1:0] = compare_a_value;
      PTM_ADDR_CMPP: next_readdata[CNT_WIDTH-1:0] = compare_p_value;
      PTM_ADDR_FLAGS: next_readdata[1:0] = {compare_p_flag, compare_a_flag};
      default: next_readdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h00000000;
      avs_waitrequest <= 1'b1;
    end else begin
      avs_readdata <= next_readdata;
      avs_waitrequest <= ~((avs_read | avs_write) & ~accessDone);
    end
  end
endmodule
`default_nettype wire

//--- dv/ptm_timer_assertions.sv
// assertion checker for the periodic timer block
`timescale 1ns/1ps
`default_nettype none
module ptm_timer_chk
  import ptm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // pins
  input wire logic timer_clock_pin,
  input wire logic timer_output_pin,
  input wire logic timer_output_pin_oe_b
);
  logic [7:0] c0;
  logic [7:0] c1;
  logic [1:0] age;
  logic wrDone;
  logic stab;
  assign wrDone = avs_write && !avs_waitrequest;
  assign stab = age == 2'h3;
  // shadow of the control registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      c0 <= 8'h00;
      c1 <= 8'h00;
    end else if (wrDone && avs_address == PTM_ADDR_CTRL0) begin
      c0 <= avs_writedata[7:0];
    end else if (wrDone && avs_address == PTM_ADDR_CTRL1) begin
      c1 <= avs_writedata[7:0];
    end
  end
  // cycles since the last control write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      age <= 2'h0;
    end else if (wrDone && avs_address[3:1] == 3'h0) begin
      age <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for two cycles");
  AST_WAIT_ANS: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[0:2] !avs_waitrequest)
    else $error("access not answered");
  AST_IDLE_HIGH: assert property ((!avs_read && !avs_write) [*2] |-> avs_waitrequest)
    else $error("waitrequest low while idle");
  AST_UNMAP: assert property (avs_read && !avs_waitrequest && avs_address > 4'h5 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_TMR_OE: assert property (stab && c1[7:6] == 2'b11 |-> timer_output_pin_oe_b)
    else $error("pin driven in timer mode");
  AST_DRV_OE: assert property (stab && c0[3] && !c1[6] |-> !timer_output_pin_oe_b)
    else $error("pin not driven");
  AST_PWM_FORCE: assert property (stab && c0[3] && c1[7:5] == 3'b100 |->
    timer_output_pin == (!(c1[4] ^ c1[3]) ^ c1[2]))
    else $error("forced pwm level wrong");
  AST_ON_RESTORE: assert property ($rose(c0[3]) && c1[7:6] == 2'b00 |->
    ##[1:3] timer_output_pin == (c1[3] ^ c1[2]))
    else $error("initial level not restored");
  COV_PWM: cover property (stab && c0[3] && c1[7:6] == 2'b10);
  COV_ON: cover property ($rose(c0[3]));
  COV_CTRL: cover property (wrDone && avs_address == PTM_ADDR_CTRL1);
  COV_PULSE: cover property (stab && c0[3] && c1[7:4] == 4'hB);
endmodule
bind ptm_timer ptm_timer_chk i_ptm_timer_chk (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .timer_clock_pin(timer_clock_pin),
  .timer_output_pin(timer_output_pin), .timer_output_pin_oe_b(timer_output_pin_oe_b));
`default_nettype wire

//--- dv/ptm_ext_model.sv
// model of the circuitry on the timer pins
`timescale 1ns/1ps
`default_nettype none
module ptm_ext_model (
  // clock
  input wire logic clk,
  // control
  input wire logic runClk,
  // pins
  input wire logic outPin,
  output logic clkPin,
  output int edges
);
  logic [2:0] div;
  logic lastOut;
  initial begin
    div = 3'h0;
    clkPin = 1'b0;
    edges = 0;
    lastOut = 1'b1;
  end
  // clock stands low unless running
  always @(posedge clk) begin
    div <= div + 3'h1;
    clkPin <= runClk & div[2];
    lastOut <= outPin;
    if (outPin !== lastOut) begin
      edges <= edges + 1;
    end
  end
endmodule
`default_nettype wire

//--- dv/ptm_timer_tb_top.sv
// self-checking testbench for the periodic timer block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin err_total++; \
  $display("mismatch %s exp %0h got %0h", n, e, a); end end
module ptm_timer_tb_top;
  import ptm_pkg::*;
  localparam int PC [5] = '{0, 1, 2, 2, 2};
  localparam int PA [5] = '{3, 3, 20, 3, 256};
  localparam int PP [5] = '{8, 8, 8, 8, 0};
  localparam int PW [5] = '{80, 80, 80, 80, 1024};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'hF;
  logic [31:0] rdat;
  logic wq;
  logic pin;
  logic oeB;
  logic ckPin;
  logic runClk = 1'b0;
  logic pad;
  logic [31:0] q;
  logic [7:0] r;
  int edges;
  int n;
  int err_total = 0;
  int checks_done = 0;
  int seed = 48;
  // pull-up on the released pin
  assign pad = oeB ? 1'b1 : pin;
  always #5 clk = ~clk;
  ptm_timer i_ptm_timer (.clk(clk), .rst_b(rst_b), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wq),
    .timer_clock_pin(ckPin), .timer_output_pin(pin), .timer_output_pin_oe_b(oeB));
  ptm_ext_model i_ptm_ext_model (.clk(clk), .runClk(runClk), .outPin(pad), .clkPin(ckPin), .edges(edges));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
    int k;
    k = 0;
    adr <= a;
    wd <= {16'h0, d};
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      k++;
    end while (wq !== 1'b0 && k < 20);
    q = rdat;
    if (k >= 20) begin
      err_total++;
      tally_and_finish();
    end
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic run(input logic [7:0] c1, input logic [7:0] c0, input logic [15:0] a, input logic [15:0] p);
    acc(1'b1, PTM_ADDR_CTRL0, 16'h10);
    acc(1'b1, PTM_ADDR_CTRL1, {8'h0, c1});
    acc(1'b1, PTM_ADDR_CMPA, a);
    acc(1'b1, PTM_ADDR_CMPP, p);
    acc(1'b1, PTM_ADDR_FLAGS, 16'h3);
    acc(1'b1, PTM_ADDR_CTRL0, {8'h0, c0});
  endtask
  function automatic logic cmpPin(input logic [1:0] c, input logic l, input logic v);
    cmpPin = ((c == 2'b00) ? l : c[1]) ^ v;
  endfunction
  function automatic int actCnt(input int c, input int a, input int p, input int w);
    int pe;
    pe = (p == 0) ? 1024 : p;
    actCnt = (c == 0) ? 0 : (c == 1 || a >= pe) ? w : w / pe * a;
  endfunction
  initial begin
    #300000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    acc(1'b0, PTM_ADDR_CTRL1, 16'h0);
    `CHK("ctrl1 reset", 32'h0, q)
    acc(1'b0, 4'hF, 16'h0);
    `CHK("unmapped", 32'h0, q)
    r = $random(seed);
    r = {2'b11, r[5:2], 1'b0, r[0]};
    acc(1'b1, PTM_ADDR_CTRL1, {8'h0, r});
    acc(1'b0, PTM_ADDR_CTRL1, 16'h0);
    `CHK("ctrl1", {24'h0, r}, q)
    for (int c = 0; c < 3; c++) begin
      for (int l = 0; l < 2; l++) begin
        r = $random(seed);
        run({2'b00, c[1:0], l[0], r[0], 2'b01}, 8'h18, 16'(8 + r[3:1]), 16'h4);
        wt(2);
        `CHK("initial", cmpPin(2'b00, l[0], r[0]), pad)
        wt(30);
        `CHK("cmp pin", cmpPin(c[1:0], l[0], r[0]), pad)
        acc(1'b0, PTM_ADDR_FLAGS, 16'h0);
        `CHK("flags clr1", 32'h1, q)
      end
    end
    run(8'h20, 8'h18, 16'hC, 16'h14);
    wt(40);
    acc(1'b0, PTM_ADDR_FLAGS, 16'h0);
    `CHK("flags clr0", 32'h3, q)
    acc(1'b1, PTM_ADDR_CTRL0, 16'h10);
    acc(1'b0, PTM_ADDR_COUNT, 16'h0);
    r = q[7:0];
    `CHK("count range", 1'b1, q < 20)
    wt(5);
    acc(1'b0, PTM_ADDR_COUNT, 16'h0);
    `CHK("held count", {24'h0, r}, q)
    acc(1'b1, PTM_ADDR_CTRL0, 16'h18);
    acc(1'b0, PTM_ADDR_COUNT, 16'h0);
    `CHK("restart", 1'b1, q < 32'h2)
    run(8'h31, 8'h18, 16'h9, 16'h4);
    n = edges;
    wt(100);
    `CHK("toggles", 1'b1, edges - n >= 8)
    runClk <= 1'b1;
    run(8'hC1, 8'h68, 16'h3, 16'h0);
    wt(120);
    acc(1'b0, PTM_ADDR_FLAGS, 16'h0);
    `CHK("ext clock flag", 32'h1, q)
    `CHK("timer oe", 1'b1, oeB)
    runClk <= 1'b0;
    run(8'hC1, 8'h18, 16'h0, 16'h5);
    wt(1100);
    acc(1'b0, PTM_ADDR_FLAGS, 16'h0);
    `CHK("zero a flags", 32'h0, q)
    run(8'h40, 8'h18, 16'h3, 16'h0);
    wt(4);
    `CHK("undef oe", 1'b1, oeB)
    for (int k = 0; k < 5; k++) begin
      r = $random(seed);
      run({2'b10, PC[k][1:0], r[0], r[1], 1'b0, r[2]}, 8'h18, 16'(PA[k]), 16'(PP[k]));
      wt(16);
      n = 0;
      repeat (PW[k]) begin
        @(posedge clk);
        n += int'(pad === (r[0] ^ r[1]));
      end
      `CHK("pwm active", actCnt(PC[k], PA[k], PP[k], PW[k]), n)
    end
    run(8'hB8, 8'h18, 16'h6, 16'h0);
    n = 0;
    repeat (40) begin
      @(posedge clk);
      n += int'(pad === 1'b1);
    end
    `CHK("pulse width", 32'h6, n)
    acc(1'b0, PTM_ADDR_CTRL0, 16'h0);
    `CHK("pulse off", 32'h10, q)
    acc(1'b0, PTM_ADDR_FLAGS, 16'h0);
    `CHK("pulse flag", 32'h1, q)
    tally_and_finish();
  end
endmodule
`default_nettype wire
